// File: rtl/fpc_consts.svh
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// Register indexes; byte address on APB is four times the index
`define FPC_IDX_LDEV 8'h07
`define FPC_IDX_STATUS 8'h08
`define FPC_IDX_MODE 8'hf0
`define FPC_IDX_OPTION 8'hf1
`define FPC_IDX_TYPE 8'hf2
`define FPC_IDX_RSVD 8'hf3
`define FPC_IDX_DRV0 8'hf4
`define FPC_IDX_DRV1 8'hf5

// Logical device numbers
`define FPC_LDEV_FLOPPY 8'h00
`define FPC_LDEV_PARALLEL 8'h03

// Reset values
`define FPC_RST_LDEV 8'h00
`define FPC_RST_FMODE 8'h0e
`define FPC_RST_FOPT 8'h00
`define FPC_RST_FTYPE 8'hff
`define FPC_RST_DRV 8'h00
`define FPC_RST_PMODE 8'h3c
`define FPC_RST_PMUX 8'h00

// Storage masks; cleared bits read as zero
`define FPC_MASK_FMODE 8'hdf
`define FPC_MASK_FOPT 8'hfc
`define FPC_MASK_DRV 8'h5b
`define FPC_MASK_PMUX 8'h03

// Floppy mode fields
`define FPC_FM_ENH 0
`define FPC_FM_NONBURST 1
`define FPC_FM_PERS 2
`define FPC_FM_SWAP 4
`define FPC_FM_PUSHPULL 6
`define FPC_FM_TRISTATE 7

// Floppy option fields
`define FPC_FO_DENS 2
`define FPC_FO_MID0INV 4
`define FPC_FO_MID1INV 5
`define FPC_FO_BOOT 6

// Per-drive fields
`define FPC_DR_TYPE 0
`define FPC_DR_RATE 3
`define FPC_DR_PRECOMP 6

// Parallel mode fields
`define FPC_PM_MODE 0
`define FPC_PM_THRESH 3
`define FPC_PM_IRQTYPE 7

// Timing
`define FPC_CLK_PERIOD_NS 5
`define FPC_IRQ_PULSE_NS 100
`define FPC_IRQ_PULSE_CYC \
  ((`FPC_IRQ_PULSE_NS + `FPC_CLK_PERIOD_NS - 1) / `FPC_CLK_PERIOD_NS)

`endif

// File: rtl/fpc_ldev_config.sv
`include "fpc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module fpc_ldev_config (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // Floppy core requests, active high
  input wire logic [1:0] fdc_drive_sel_in,
  input wire logic [1:0] fdc_motor_in,
  input wire logic fdc_density_in,
  // Floppy pins, active low {motor1, motor0, sel1, sel0}
  output logic [3:0] fdd_ctl_n_out,
  output logic [3:0] fdd_ctl_oe_out,
  output logic fdd_density_out,
  output logic fdd_density_oe_out,
  input wire logic [1:0] media_id_in,
  // Floppy signals muxed onto parallel pins, active low
  output logic [3:0] pp_fdd_ctl_n_out,
  output logic [3:0] pp_fdd_ctl_oe_out,
  // Floppy core configuration
  output logic enhanced_mode_out,
  output logic non_burst_dma_out,
  output fpc_pkg::fpc_pers_t personality_out,
  output logic [1:0] media_id_out,
  output logic boot_drive_out,
  output logic boot_valid_out,
  output logic [3:0] drive_type_bits_out,
  output logic [3:0] rate_table_bits_out,
  output logic [1:0] precomp_disable_out,
  // Parallel port configuration
  output fpc_pkg::fpc_pp_mode_t pp_mode_out,
  output logic [3:0] pp_fifo_thresh_out,
  output logic [1:0] pp_floppy_mux_sel_out,
  // Parallel interrupt
  input wire logic pp_ack_n_in,
  input wire logic pp_irq_enable_in,
  input wire logic pp_irq_level_in,
  output logic pp_irq_out,
  output logic pp_irq_oe_out
);
  import fpc_pkg::*;
  localparam int PULSE_CYC = `FPC_IRQ_PULSE_CYC;

  // Configuration storage
  logic [7:0] ldev_select, floppy_mode_config, floppy_option_config;
  logic [7:0] drive_type_store, drive0_params, drive1_params;
  logic [7:0] parallel_mode_config, parallel_floppy_mux_config;

  // Bus decode
  logic [7:0] bus_index;
  logic addr_ok, setup_phase, write_commit;
  logic [8:0] read_word;

  // Pin synchronisers
  logic [1:0] mid_s1, mid_s2, mid_s3, mid_level;
  logic ack_s1, ack_s2, ack_s3, ack_level;

  // Interrupt sequencer
  fpc_irq_state_t irq_state, next_irq_state;
  logic [7:0] pulse_count;
  logic irq_src, irq_src_d, pulse_mode;

  // Floppy routing
  logic [1:0] sel_phys, mot_phys, on_pp;
  logic [3:0] ctl_active, ctl_on_pp;
  logic density_level;

  // Decode an index for the selected logical device; bit 8 flags a hit
  function automatic logic [8:0] decode_read(input logic [7:0] idx);
    logic [8:0] r;
    r = 9'h000;
    if (idx == `FPC_IDX_LDEV) begin
      r = {1'b1, ldev_select};
    end else if (idx == `FPC_IDX_STATUS) begin
      r = {1'b1, 4'h0, irq_state == FPC_IRQ_PULSE, ack_level, mid_level};
    end else if (ldev_select == `FPC_LDEV_FLOPPY) begin
      case (idx)
        `FPC_IDX_MODE: r = {1'b1, floppy_mode_config};
        `FPC_IDX_OPTION: r = {1'b1, floppy_option_config};
        `FPC_IDX_TYPE: r = {1'b1, drive_type_store};
        `FPC_IDX_RSVD: r = {1'b1, 8'h00};
        `FPC_IDX_DRV0: r = {1'b1, drive0_params};
        `FPC_IDX_DRV1: r = {1'b1, drive1_params};
        default: r = 9'h000;
      endcase
    end else if (ldev_select == `FPC_LDEV_PARALLEL) begin
      case (idx)
        `FPC_IDX_MODE: r = {1'b1, parallel_mode_config};
        `FPC_IDX_OPTION: r = {1'b1, parallel_floppy_mux_config};
        default: r = 9'h000;
      endcase
    end
    return r;
  endfunction

  // Word aligned addresses only; index sits in bits 9:2
  assign bus_index = paddr_in[9:2];
  assign addr_ok = (paddr_in[11:10] == 2'b00) && (paddr_in[1:0] == 2'b00);
  assign setup_phase = psel_in && !penable_in;
  assign write_commit = psel_in && penable_in && pready_out && pwrite_in
                        && pstrb_in[0] && addr_ok;
  assign read_word = addr_ok ? decode_read(bus_index) : 9'h000;

  // Answer one cycle after setup, so access completes without wait
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else if (setup_phase) begin
      pready_out <= 1'b1;
      pslverr_out <= !read_word[8];
      prdata_out <= (pwrite_in || !read_word[8]) ? 32'h0000_0000
                    : {24'h00_0000, read_word[7:0]};
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end
  end

  // Logical device selector
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ldev_select <= `FPC_RST_LDEV;
    end else if (write_commit && bus_index == `FPC_IDX_LDEV) begin
      ldev_select <= pwdata_in[7:0];
    end
  end

  // Floppy bank; only the hard reset clears it, no soft reset term
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      floppy_mode_config <= `FPC_RST_FMODE;
      floppy_option_config <= `FPC_RST_FOPT;
      drive_type_store <= `FPC_RST_FTYPE;
      drive0_params <= `FPC_RST_DRV;
      drive1_params <= `FPC_RST_DRV;
    end else if (write_commit && ldev_select == `FPC_LDEV_FLOPPY) begin
      // Reserved bits are dropped so they always read zero
      case (bus_index)
        `FPC_IDX_MODE: floppy_mode_config <= pwdata_in[7:0] & `FPC_MASK_FMODE;
        `FPC_IDX_OPTION:
          floppy_option_config <= pwdata_in[7:0] & `FPC_MASK_FOPT;
        `FPC_IDX_TYPE: drive_type_store <= pwdata_in[7:0];
        `FPC_IDX_DRV0:
          drive0_params <= pwdata_in[7:0] & `FPC_MASK_DRV;
        `FPC_IDX_DRV1:
          drive1_params <= pwdata_in[7:0] & `FPC_MASK_DRV;
        default: ;
      endcase
    end
  end

  // Parallel bank, same hard-reset-only behaviour
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      parallel_mode_config <= `FPC_RST_PMODE;
      parallel_floppy_mux_config <= `FPC_RST_PMUX;
    end else if (write_commit && ldev_select == `FPC_LDEV_PARALLEL) begin
      case (bus_index)
        `FPC_IDX_MODE: parallel_mode_config <= pwdata_in[7:0];
        `FPC_IDX_OPTION:
          parallel_floppy_mux_config <= pwdata_in[7:0] & `FPC_MASK_PMUX;
        default: ;
      endcase
    end
  end

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      mid_s1 <= 2'b00;
      mid_s2 <= 2'b00;
      mid_s3 <= 2'b00;
      mid_level <= 2'b00;
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
      ack_s3 <= 1'b1;
      ack_level <= 1'b1;
    end else begin
      mid_s1 <= media_id_in;
      mid_s2 <= mid_s1;
      mid_s3 <= mid_s2;
      ack_s1 <= pp_ack_n_in;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      for (int i = 0; i < 2; i++) begin
        if (mid_s2[i] == mid_s3[i]) begin
          mid_level[i] <= mid_s3[i];
        end
      end
      if (ack_s2 == ack_s3) begin
        ack_level <= ack_s3;
      end
    end
  end

  // Swap, then route each physical drive to floppy or parallel pins
  always_comb begin
    if (floppy_mode_config[`FPC_FM_SWAP]) begin
      sel_phys = {fdc_drive_sel_in[0], fdc_drive_sel_in[1]};
      mot_phys = {fdc_motor_in[0], fdc_motor_in[1]};
    end else begin
      sel_phys = fdc_drive_sel_in;
      mot_phys = fdc_motor_in;
    end
    case (parallel_floppy_mux_config[1:0])
      2'b01: on_pp = 2'b10;
      2'b10: on_pp = 2'b11;
      default: on_pp = 2'b00;
    endcase
    ctl_active = {mot_phys, sel_phys};
    ctl_on_pp = {on_pp, on_pp};
    case (floppy_option_config[`FPC_FO_DENS +: 2])
      2'b10: density_level = 1'b1;
      2'b11: density_level = 1'b0;
      default: density_level = fdc_density_in;
    endcase
  end

  // Floppy pin drivers; open drain only pulls low, tri-state wins over all
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      fdd_ctl_n_out <= 4'hf;
      fdd_ctl_oe_out <= 4'h0;
      fdd_density_out <= 1'b1;
      fdd_density_oe_out <= 1'b0;
    end else if (floppy_mode_config[`FPC_FM_TRISTATE]) begin
      fdd_ctl_n_out <= 4'hf;
      fdd_ctl_oe_out <= 4'h0;
      fdd_density_out <= 1'b1;
      fdd_density_oe_out <= 1'b0;
    end else if (floppy_mode_config[`FPC_FM_PUSHPULL]) begin
      fdd_ctl_n_out <= ~(ctl_active & ~ctl_on_pp);
      fdd_ctl_oe_out <= 4'hf;
      fdd_density_out <= density_level;
      fdd_density_oe_out <= 1'b1;
    end else begin
      fdd_ctl_n_out <= 4'h0;
      fdd_ctl_oe_out <= ctl_active & ~ctl_on_pp;
      fdd_density_out <= 1'b0;
      fdd_density_oe_out <= !density_level;
    end
  end

  // Parallel-pin floppy signals ignore output type and tri-state bits
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pp_fdd_ctl_n_out <= 4'hf;
      pp_fdd_ctl_oe_out <= 4'h0;
    end else begin
      pp_fdd_ctl_n_out <= ~(ctl_active & ctl_on_pp);
      pp_fdd_ctl_oe_out <= ctl_on_pp;
    end
  end

  // Floppy core configuration outputs
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      enhanced_mode_out <= 1'b0;
      non_burst_dma_out <= 1'b1;
      personality_out <= FPC_PERS_DEFAULT;
      media_id_out <= 2'b00;
      boot_drive_out <= 1'b0;
      boot_valid_out <= 1'b1;
      drive_type_bits_out <= 4'h0;
      rate_table_bits_out <= 4'h0;
      precomp_disable_out <= 2'b00;
    end else begin
      enhanced_mode_out <= floppy_mode_config[`FPC_FM_ENH];
      non_burst_dma_out <= floppy_mode_config[`FPC_FM_NONBURST];
      personality_out <=
        fpc_pers_t'(floppy_mode_config[`FPC_FM_PERS +: 2]);
      media_id_out <= mid_level ^ {floppy_option_config[`FPC_FO_MID1INV],
        floppy_option_config[`FPC_FO_MID0INV]};
      boot_drive_out <= floppy_option_config[`FPC_FO_BOOT];
      boot_valid_out <= !floppy_option_config[`FPC_FO_BOOT + 1];
      drive_type_bits_out <= {drive1_params[`FPC_DR_TYPE +: 2],
        drive0_params[`FPC_DR_TYPE +: 2]};
      rate_table_bits_out <= {drive1_params[`FPC_DR_RATE +: 2],
        drive0_params[`FPC_DR_RATE +: 2]};
      precomp_disable_out <= {drive1_params[`FPC_DR_PRECOMP],
        drive0_params[`FPC_DR_PRECOMP]};
    end
  end

  // Parallel configuration outputs
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pp_mode_out <= FPC_PP_PRINTER;
      pp_fifo_thresh_out <= 4'h7;
      pp_floppy_mux_sel_out <= 2'b00;
    end else begin
      pp_mode_out <=
        fpc_pp_mode_t'(parallel_mode_config[`FPC_PM_MODE +: 3]);
      pp_fifo_thresh_out <=
        parallel_mode_config[`FPC_PM_THRESH +: 4];
      pp_floppy_mux_sel_out <= parallel_floppy_mux_config[1:0];
    end
  end

  // Interrupt source: level request when mode bit 1 is set (ECP-type modes and 110), else the ack line
  always_comb begin
    irq_src = parallel_mode_config[1] ? pp_irq_level_in : ack_level;
    case (fpc_pp_mode_t'(parallel_mode_config[`FPC_PM_MODE +: 3]))
      FPC_PP_PRINTER, FPC_PP_SPP: pulse_mode = 1'b0;
      default: pulse_mode = parallel_mode_config[`FPC_PM_IRQTYPE];
    endcase
  end

  // Pulse sequencer; a rising source restarts nothing mid-pulse
  always_comb begin
    next_irq_state = irq_state;
    case (irq_state)
      FPC_IRQ_IDLE: begin
        if (pulse_mode && pp_irq_enable_in && irq_src && !irq_src_d) begin
          next_irq_state = FPC_IRQ_PULSE;
        end
      end
      FPC_IRQ_PULSE: begin
        if (pulse_count == 8'(PULSE_CYC - 1)) begin
          next_irq_state = FPC_IRQ_IDLE;
        end
      end
      default: next_irq_state = FPC_IRQ_IDLE;
    endcase
  end

  // Source history resets to the idle ack level, so no false edge
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      irq_state <= FPC_IRQ_IDLE;
      pulse_count <= 8'h00;
      irq_src_d <= 1'b1;
    end else begin
      irq_state <= next_irq_state;
      irq_src_d <= irq_src;
      if (irq_state == FPC_IRQ_PULSE) begin
        pulse_count <= pulse_count + 8'h01;
      end else begin
        pulse_count <= 8'h00;
      end
    end
  end

  // Interrupt pin: pulse drives low then floats; otherwise follows source
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pp_irq_out <= 1'b0;
      pp_irq_oe_out <= 1'b0;
    end else if (pulse_mode) begin
      pp_irq_out <= 1'b0;
      pp_irq_oe_out <= next_irq_state == FPC_IRQ_PULSE;
    end else begin
      pp_irq_out <= irq_src;
      pp_irq_oe_out <= pp_irq_enable_in;
    end
  end

endmodule // fpc_ldev_config

`default_nettype wire

// File: rtl/fpc_pkg.sv
package fpc_pkg;

  // Parallel port operating modes
  typedef enum logic [2:0] {
    FPC_PP_SPP = 3'b000,
    FPC_PP_EPP19 = 3'b001,
    FPC_PP_ECP = 3'b010,
    FPC_PP_ECP_EPP19 = 3'b011,
    FPC_PP_PRINTER = 3'b100,
    FPC_PP_EPP17 = 3'b101,
    FPC_PP_UNDEF = 3'b110,
    FPC_PP_ECP_EPP17 = 3'b111
  } fpc_pp_mode_t;

  // Host interface personalities
  typedef enum logic [1:0] {
    FPC_PERS_THIRD = 2'b00,
    FPC_PERS_SECOND = 2'b01,
    FPC_PERS_RSVD = 2'b10,
    FPC_PERS_DEFAULT = 2'b11
  } fpc_pers_t;

  // Pulsed interrupt sequencer
  typedef enum logic [0:0] {
    FPC_IRQ_IDLE = 1'b0,
    FPC_IRQ_PULSE = 1'b1
  } fpc_irq_state_t;

endpackage

// File: testbench/fpc_ldev_checker.sv
`timescale 1ns/10ps
`default_nettype none

module fpc_ldev_checker (
  // Clock, reset and APB
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [31:0] prdata_out,
  // Configuration and pins
  input wire logic non_burst_dma_out,
  input var fpc_pkg::fpc_pp_mode_t pp_mode_out,
  input wire logic [3:0] pp_fifo_thresh_out,
  input wire logic [1:0] pp_floppy_mux_sel_out,
  input wire logic [3:0] pp_fdd_ctl_n_out,
  input wire logic [3:0] pp_fdd_ctl_oe_out,
  input wire logic pp_irq_oe_out
);
  import fpc_pkg::*;
  logic [3:0] routed;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  // Pins that the mux may hand to the parallel port
  assign routed = (pp_floppy_mux_sel_out == 2'b01) ? 4'ha :
                  (pp_floppy_mux_sel_out == 2'b10) ? 4'hf : 4'h0;

  chk_ready_setup: assert property (
    psel_in && !penable_in |=> pready_out) else $error("no answer");
  chk_ready_single: assert property (
    pready_out |=> !pready_out) else $error("ready too long");
  chk_ready_idle: assert property (
    !psel_in |=> !pready_out) else $error("ready without request");
  chk_err_zero: assert property (
    pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("error answer malformed");
  chk_write_data: assert property (
    pready_out && $past(pwrite_in) |-> prdata_out == 32'h0)
    else $error("data on write");
  chk_upper_zero: assert property (
    pready_out |-> prdata_out[31:8] == 24'h0) else $error("upper bits");
  chk_reset_default: assert property (
    $fell(sys_rst_in) |-> pp_mode_out == FPC_PP_PRINTER &&
    pp_fifo_thresh_out == 4'h7 && non_burst_dma_out)
    else $error("defaults lost");
  chk_pp_pin_drive: assert property (
    (~pp_fdd_ctl_n_out & ~pp_fdd_ctl_oe_out) == 4'h0)
    else $error("undriven active pin");
  chk_mux_route: assert property (
    $stable(pp_floppy_mux_sel_out) |-> (pp_fdd_ctl_oe_out & ~routed) == 4'h0)
    else $error("unrouted drive on parallel pins");

  // Main scenarios
  cover property (pslverr_out);
  cover property (pready_out && !pslverr_out);
  cover property (pp_fdd_ctl_oe_out == 4'hf);
  cover property ($rose(pp_irq_oe_out));
endmodule // fpc_ldev_checker

`default_nettype wire

// File: testbench/tb.sv
`include "fpc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
`define CMP(a, b) begin num_checks++; if ((a) !== (b)) begin \
  error_cnt++; $display("MISMATCH t=%0t got %h exp %h", $time, a, b); \
  end end

module tb;
  import fpc_pkg::*;
  logic sys_clk_in, sys_rst_in, psel_in, penable_in, pwrite_in;
  logic pready_out, pslverr_out, fdc_density_in;
  logic fdd_density_out, fdd_density_oe_out, enhanced_mode_out;
  logic non_burst_dma_out, boot_drive_out, boot_valid_out;
  logic pp_ack_n_in, pp_irq_enable_in, pp_irq_level_in;
  logic pp_irq_out, pp_irq_oe_out, er, lv, pulse, bad;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic [3:0] pstrb_in, fdd_ctl_n_out, fdd_ctl_oe_out, pp_fifo_thresh_out;
  logic [3:0] pp_fdd_ctl_n_out, pp_fdd_ctl_oe_out;
  logic [3:0] drive_type_bits_out, rate_table_bits_out;
  logic [1:0] fdc_drive_sel_in, fdc_motor_in, media_id_in, media_id_out;
  logic [1:0] precomp_disable_out, pp_floppy_mux_sel_out;
  fpc_pers_t personality_out;
  fpc_pp_mode_t pp_mode_out;
  logic [7:0] rdv, r, q, cnt;
  logic [7:0] fm [6] = '{8'h0e, 8'h4e, 8'h8e, 8'h1e, 8'h5e, 8'hce};
  int error_cnt, num_checks;

  fpc_ldev_config fpc_ldev_config_i (.*);

  // Free-running 200 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {2'b00, i, 2'b00};
    pwdata_in <= {24'h0, d};
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rdv = prdata_out[7:0];
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    `CMP(pready_out, 1'b1)
  endtask

  task automatic sel(input logic [7:0] ld);
    apb(1'b1, `FPC_IDX_LDEV, ld);
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    `CMP({er, rdv}, {1'b0, e})
  endtask

  // Whole bank against its documented defaults
  task automatic defaults;
    sel(`FPC_LDEV_FLOPPY);
    rd(`FPC_IDX_MODE, 8'h0e);
    rd(`FPC_IDX_OPTION, 8'h00);
    rd(`FPC_IDX_TYPE, 8'hff);
    rd(`FPC_IDX_RSVD, 8'h00);
    rd(`FPC_IDX_DRV0, 8'h00);
    rd(`FPC_IDX_DRV1, 8'h00);
    sel(`FPC_LDEV_PARALLEL);
    rd(`FPC_IDX_MODE, 8'h3c);
    rd(`FPC_IDX_OPTION, 8'h00);
    `CMP(pp_mode_out, FPC_PP_PRINTER)
  endtask

  // Expected {fdd n, fdd oe, pp n, pp oe} for one setting
  function automatic logic [15:0] pins(logic [7:0] m, logic [1:0] x,
                                       logic [1:0] s, logic [1:0] t);
    logic [3:0] a, rt, n, oe;
    a = m[4] ? {t[0], t[1], s[0], s[1]} : {t, s};
    rt = (x == 2'b01) ? 4'ha : (x == 2'b10) ? 4'hf : 4'h0;
    n = m[6] ? ~(a & ~rt) : 4'h0;
    oe = m[6] ? 4'hf : (a & ~rt);
    if (m[7]) begin
      n = 4'hf;
      oe = 4'h0;
    end
    return {n, oe, ~(a & rt), rt};
  endfunction

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end

  initial begin
    void'($urandom(5566));
    {sys_rst_in, pp_ack_n_in, pp_irq_enable_in, pstrb_in} = 7'h7f;
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {fdc_drive_sel_in, fdc_motor_in, fdc_density_in} = '0;
    {media_id_in, pp_irq_level_in} = '0;
    error_cnt = 0;
    num_checks = 0;
    repeat (20) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    defaults();
    // Random register traffic, all-ones corner first
    for (int k = 0; k < 12; k++) begin
      r = (k == 0) ? 8'hff : 8'($urandom);
      q = (k == 0) ? 8'hff : 8'($urandom);
      sel(`FPC_LDEV_FLOPPY);
      apb(1'b1, `FPC_IDX_MODE, r);
      apb(1'b1, `FPC_IDX_TYPE, q);
      apb(1'b1, `FPC_IDX_DRV0, r);
      apb(1'b1, `FPC_IDX_DRV1, q);
      apb(1'b1, `FPC_IDX_RSVD, r);
      sel(`FPC_LDEV_PARALLEL);
      apb(1'b1, `FPC_IDX_MODE, r);
      apb(1'b1, `FPC_IDX_OPTION, q);
      rd(`FPC_IDX_MODE, r);
      rd(`FPC_IDX_OPTION, q & 8'h03);
      `CMP({pp_fifo_thresh_out, pp_mode_out}, r[6:0])
      sel(`FPC_LDEV_FLOPPY);
      rd(`FPC_IDX_MODE, r & 8'hdf);
      rd(`FPC_IDX_TYPE, q);
      rd(`FPC_IDX_DRV0, r & 8'h5b);
      rd(`FPC_IDX_DRV1, q & 8'h5b);
      rd(`FPC_IDX_RSVD, 8'h00);
      `CMP({enhanced_mode_out, non_burst_dma_out, personality_out},
        {r[0], r[1], r[3:2]})
      `CMP({drive_type_bits_out, rate_table_bits_out},
        {q[1:0], r[1:0], q[4:3], r[4:3]})
      `CMP(precomp_disable_out, {q[6], r[6]})
    end
    // Unmapped and unselected indexes are refused
    apb(1'b0, 8'h40, 8'h00);
    `CMP({er, rdv}, 9'h100)
    sel(`FPC_LDEV_PARALLEL);
    apb(1'b1, `FPC_IDX_TYPE, 8'h00);
    `CMP({er, rdv}, 9'h100)
    sel(`FPC_LDEV_FLOPPY);
    rd(`FPC_IDX_TYPE, q);
    // Output buffer modes, swap and mux routing
    foreach (fm[k]) begin
      for (int x = 0; x < 4; x++) begin
        sel(`FPC_LDEV_PARALLEL);
        apb(1'b1, `FPC_IDX_OPTION, 8'(x));
        sel(`FPC_LDEV_FLOPPY);
        apb(1'b1, `FPC_IDX_MODE, fm[k]);
        `CMP(pp_floppy_mux_sel_out, 2'(x))
        repeat (4) begin
          fdc_drive_sel_in <= 2'($urandom);
          fdc_motor_in <= 2'($urandom);
          repeat (2) @(posedge sys_clk_in);
          `CMP({fdd_ctl_n_out, fdd_ctl_oe_out, pp_fdd_ctl_n_out,
            pp_fdd_ctl_oe_out}, pins(fm[k], 2'(x), fdc_drive_sel_in,
            fdc_motor_in))
        end
      end
    end
    // Density, media-ID polarity and boot drive
    for (int k = 0; k < 8; k++) begin
      r = 8'($urandom);
      r[3:2] = k[1:0];
      fdc_density_in <= 1'($urandom);
      media_id_in <= 2'($urandom);
      apb(1'b1, `FPC_IDX_MODE, k[2] ? 8'h4e : 8'h0e);
      apb(1'b1, `FPC_IDX_OPTION, r);
      repeat (6) @(posedge sys_clk_in);
      lv = (r[3:2] == 2'b10) ? 1'b1 :
        (r[3:2] == 2'b11) ? 1'b0 : fdc_density_in;
      `CMP({fdd_density_out, fdd_density_oe_out},
        k[2] ? {lv, 1'b1} : {1'b0, ~lv})
      `CMP(media_id_out, media_id_in ^ r[5:4])
      `CMP({boot_drive_out, boot_valid_out}, {r[6], ~r[7]})
    end
    // Interrupt style across every mode and both type settings
    sel(`FPC_LDEV_PARALLEL);
    for (int k = 0; k < 16; k++) begin
      pp_ack_n_in <= 1'b0;
      pp_irq_level_in <= 1'b0;
      repeat (25) @(posedge sys_clk_in);
      apb(1'b1, `FPC_IDX_MODE, {k[3], 4'h7, k[2:0]});
      repeat (25) @(posedge sys_clk_in);
      pp_ack_n_in <= 1'b1;
      pp_irq_level_in <= 1'b1;
      cnt = 8'h00;
      bad = 1'b0;
      repeat (40) begin
        @(posedge sys_clk_in);
        cnt = cnt + 8'(pp_irq_oe_out);
        bad = bad | (pp_irq_oe_out & pp_irq_out);
      end
      pulse = k[3] && k[2:0] != 3'b100 && k[2:0] != 3'b000;
      `CMP({bad & pulse, cnt, pp_irq_out},
        {1'b0, pulse ? 8'd20 : 8'd40, !pulse})
    end
    // Hard reset in mid-run restores the bank
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    defaults();
    rd(`FPC_IDX_LDEV, `FPC_LDEV_PARALLEL);
    rd(`FPC_IDX_STATUS, {6'h01, media_id_in});
    end_sim();
  end
endmodule // tb

bind fpc_ldev_config fpc_ldev_checker chk_i (.*);

`default_nettype wire
